// *** src/ccps_pkg.sv ***
// constants, types and helpers of the camera cable power sequencer
package ccps_pkg;
    localparam int unsigned REF_CLK_HZ = 50_000_000;
    localparam int unsigned REF_CLK_NS = 20;
    localparam int unsigned CLOCK_WAIT_MS = 2000;
    localparam int unsigned CLOCK_WAIT_CYCLES = CLOCK_WAIT_MS * (REF_CLK_HZ / 1000);
    localparam int unsigned PIX_LOSS_NS = 640;
    localparam int unsigned PIX_LOSS_CYCLES = (PIX_LOSS_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] STATUS_OFFSET = 8'h00;
    localparam logic [7:0] CONTROL_OFFSET = 8'h04;
    localparam int unsigned ST_POWER_BIT = 0;
    localparam int unsigned ST_GROUND_BIT = 1;
    localparam int unsigned ST_WAIT_BIT = 2;
    localparam int unsigned ST_SENSE_BIT = 4;
    localparam int unsigned ST_CLK_SEEN_BIT = 5;
    localparam int unsigned ST_FOUND_BIT = 6;
    localparam int unsigned CTL_HOLD_BIT = 0;
    localparam logic [31:0] STATUS_RESET = 32'h00000010;
    localparam logic CONTROL_HOLD_RESET = 1'b0;

    typedef enum logic [1:0] {
        CCPS_SENSE = 2'b00,
        CCPS_CLOCK_WAIT = 2'b01,
        CCPS_CLOCK_SEEN = 2'b11,
        CCPS_GROUNDED = 2'b10
    } ccps_state_type;

    // register address decode
    function automatic logic ccps_hit(input logic [7:0] addr, input logic [7:0] offset);
        return addr == offset;
    endfunction : ccps_hit
endpackage : ccps_pkg

// *** src/ccps_pix_if.sv ***
// pixel clock activity seen by the monitor and read by the sequencer
`timescale 1ns/1ps
`default_nettype none
interface ccps_pix_if;
    logic clk_alive;
    logic clk_edge;
    modport mon (output clk_alive, output clk_edge);
    modport seq (input clk_alive, input clk_edge);
endinterface : ccps_pix_if
`default_nettype wire

// *** src/ccps_sync.sv ***
// three-flop synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ccps_sync
    import ccps_pkg::*;
#(
    parameter int unsigned W = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    if (W < 1) begin : g_chk
        $error("ccps_sync width must be at least 1");
    end

    // per bit: take stage three only where it agrees with stage two
    assign out_d = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
    assign sync_out = out_q;

    // shift chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else if (ce) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end
endmodule : ccps_sync
`default_nettype wire

// *** src/ccps_clk_mon.sv ***
// pixel clock activity monitor on the synchronised pixel clock level
`timescale 1ns/1ps
`default_nettype none
module ccps_clk_mon
    import ccps_pkg::*;
#(
    parameter int unsigned LOSS_CYCLES = PIX_LOSS_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic pix_level,
    ccps_pix_if.mon pix
);
    logic last_q;
    logic [15:0] idle_q;
    logic [15:0] idle_d;
    logic rise;

    if (LOSS_CYCLES < 2 || LOSS_CYCLES > 16'hfff0) begin : g_chk
        $error("ccps_clk_mon loss window out of range");
    end

    // rising edge restarts the idle count, which saturates at the limit
    assign rise = pix_level & ~last_q;
    assign idle_d = rise ? 16'h0000 :
        ((idle_q >= LOSS_CYCLES[15:0]) ? idle_q : idle_q + 16'h0001);
    assign pix.clk_edge = rise & ce;
    assign pix.clk_alive = idle_q < LOSS_CYCLES[15:0];

    // edge and idle state; starts as a stopped clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 1'b0;
            idle_q <= 16'hffff;
        end else if (ce) begin
            last_q <= pix_level;
            idle_q <= idle_d;
        end
    end
endmodule : ccps_clk_mon
`default_nettype wire

// *** src/ccps_sequencer.sv ***
// camera cable power sequencer: state machine, status and control registers
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ccps_sequencer
    import ccps_pkg::*;
#(
    parameter int unsigned WAIT_CYCLES = CLOCK_WAIT_CYCLES,
    parameter int unsigned LOSS_CYCLES = PIX_LOSS_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic CAM_SENSE_MATCH,
    input wire logic CAM_SENSE_SHORT,
    input wire logic PIXEL_CLK,
    output logic CABLE_POWER_ENABLED,
    output logic CABLE_POWER_GROUNDED
);
    ccps_state_type state_q;
    ccps_state_type state_d;
    logic [31:0] wait_cnt_q;
    logic [31:0] wait_cnt_d;
    logic power_q;
    logic power_d;
    logic ground_q;
    logic ground_d;
    logic hold_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [2:0] pin_async;
    logic [2:0] pin_sync;
    logic cam_match;
    logic cam_short;
    logic pix_level;
    logic wait_done;
    logic status_hit;
    logic control_hit;
    logic [31:0] status_w;
    logic [31:0] control_w;
    logic cable_power_applied;
    logic cable_wires_grounded;
    logic awaiting_pixel_clock;
    logic impedance_sensing;
    logic camera_clock_seen;
    logic powered_camera_found;

    ccps_pix_if pix ();

    // parameters the counters cannot serve are refused
    if (WAIT_CYCLES < 2) begin : g_chk_wait
        $error("clock wait must be at least two cycles");
    end

    // sense pins and pixel clock come from outside the clock domain
    assign pin_async = {PIXEL_CLK, CAM_SENSE_SHORT, CAM_SENSE_MATCH};

    ccps_sync #(
        .W(3)
    ) u_sync (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .ce(CLK_EN),
        .async_in(pin_async),
        .sync_out(pin_sync)
    );

    assign cam_match = pin_sync[0];
    assign cam_short = pin_sync[1];
    assign pix_level = pin_sync[2];

    ccps_clk_mon #(
        .LOSS_CYCLES(LOSS_CYCLES)
    ) u_mon (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .ce(CLK_EN),
        .pix_level(pix_level),
        .pix(pix.mon)
    );

    // end of the clock wait window
    assign wait_done = wait_cnt_q >= (WAIT_CYCLES - 1);

    // next state; a short takes priority over a camera match for safety
    always_comb begin
        state_d = state_q;
        case (state_q)
            CCPS_SENSE: begin
                if (hold_q) begin
                    state_d = CCPS_SENSE;
                end else if (cam_short) begin
                    state_d = CCPS_GROUNDED;
                end else if (cam_match) begin
                    state_d = CCPS_CLOCK_WAIT;
                end else begin
                    state_d = CCPS_SENSE;
                end
            end
            CCPS_CLOCK_WAIT: begin
                if (hold_q) begin
                    state_d = CCPS_SENSE;
                end else if (wait_done) begin
                    state_d = pix.clk_alive ? CCPS_CLOCK_SEEN : CCPS_SENSE;
                end else begin
                    state_d = CCPS_CLOCK_WAIT;
                end
            end
            CCPS_CLOCK_SEEN: begin
                if (hold_q || !pix.clk_alive) begin
                    state_d = CCPS_SENSE;
                end else begin
                    state_d = CCPS_CLOCK_SEEN;
                end
            end
            CCPS_GROUNDED: begin
                if (hold_q || !cam_short) begin
                    state_d = CCPS_SENSE;
                end else begin
                    state_d = CCPS_GROUNDED;
                end
            end
            default: begin
                state_d = CCPS_SENSE;
            end
        endcase
    end

    // wait counter runs only inside the clock wait
    assign wait_cnt_d = (state_q == CCPS_CLOCK_WAIT && state_d == CCPS_CLOCK_WAIT)
        ? wait_cnt_q + 32'h00000001 : 32'h00000000;

    // pin drives follow the next state so they change with it
    assign power_d = (state_d == CCPS_CLOCK_WAIT) || (state_d == CCPS_CLOCK_SEEN);
    assign ground_d = state_d == CCPS_GROUNDED;

    // sequencer state, reset to sensing with power off
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= CCPS_SENSE;
            wait_cnt_q <= 32'h00000000;
            power_q <= 1'b0;
            ground_q <= 1'b0;
        end else if (CLK_EN) begin
            state_q <= state_d;
            wait_cnt_q <= wait_cnt_d;
            power_q <= power_d;
            ground_q <= ground_d;
        end
    end

    assign CABLE_POWER_ENABLED = power_q;
    assign CABLE_POWER_GROUNDED = ground_q;

    // status fields
    assign cable_power_applied = power_q;
    assign cable_wires_grounded = ground_q;
    assign awaiting_pixel_clock = state_q == CCPS_CLOCK_WAIT;
    assign impedance_sensing = state_q == CCPS_SENSE;
    assign camera_clock_seen = state_q == CCPS_CLOCK_SEEN;
    assign powered_camera_found = power_q;

    // status word, reserved bits zero
    always_comb begin
        status_w = 32'h00000000;
        status_w[ST_POWER_BIT] = cable_power_applied;
        status_w[ST_GROUND_BIT] = cable_wires_grounded;
        status_w[ST_WAIT_BIT] = awaiting_pixel_clock;
        status_w[ST_SENSE_BIT] = impedance_sensing;
        status_w[ST_CLK_SEEN_BIT] = camera_clock_seen;
        status_w[ST_FOUND_BIT] = powered_camera_found;
    end

    always_comb begin
        control_w = 32'h00000000;
        control_w[CTL_HOLD_BIT] = hold_q;
    end

    // register decode
    assign status_hit = ccps_hit(REG_ADDR, STATUS_OFFSET);
    assign control_hit = ccps_hit(REG_ADDR, CONTROL_OFFSET);
    assign rdata_d = !REG_RD ? 32'h00000000 :
        status_hit ? status_w :
        control_hit ? control_w : 32'h00000000;

    // control register; status writes fall through with no effect
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            hold_q <= CONTROL_HOLD_RESET;
        end else if (CLK_EN && REG_WR && control_hit) begin
            hold_q <= REG_WDATA[CTL_HOLD_BIT];
        end
    end

    // read data stand for the one cycle after the strobe
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q <= 32'h00000000;
        end else if (CLK_EN) begin
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;

    // checks of the sequencer against its pins and status
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);

    property p_sense_off;
        (state_q == CCPS_SENSE) |-> (!CABLE_POWER_ENABLED && !CABLE_POWER_GROUNDED);
    endproperty
    a_sense_off: assert property (p_sense_off)
        else $error("power or ground active while sensing");

    property p_power_on;
        (state_q == CCPS_SENSE && CLK_EN && !hold_q && cam_match && !cam_short)
            |=> (state_q == CCPS_CLOCK_WAIT && CABLE_POWER_ENABLED);
    endproperty
    a_power_on: assert property (p_power_on)
        else $error("camera match did not apply power");

    property p_short_ground;
        (state_q == CCPS_SENSE && CLK_EN && !hold_q && cam_short)
            |=> (CABLE_POWER_GROUNDED && !CABLE_POWER_ENABLED);
    endproperty
    a_short_ground: assert property (p_short_ground)
        else $error("short did not ground the cable");

    property p_stay_sense;
        (state_q == CCPS_SENSE && !cam_match && !cam_short) |=> (state_q == CCPS_SENSE);
    endproperty
    a_stay_sense: assert property (p_stay_sense)
        else $error("left sensing without a cause");

    property p_wait_entry;
        $rose(CABLE_POWER_ENABLED) |-> (state_q == CCPS_CLOCK_WAIT && wait_cnt_q == 32'h0);
    endproperty
    a_wait_entry: assert property (p_wait_entry)
        else $error("power applied outside the clock wait");

    property p_wait_len;
        (state_q == CCPS_CLOCK_WAIT && !hold_q) ##1 (state_q != CCPS_CLOCK_WAIT)
            |-> ($past(wait_cnt_q) == WAIT_CYCLES - 1);
    endproperty
    a_wait_len: assert property (p_wait_len)
        else $error("clock wait left early or late");

    property p_clock_loss;
        (state_q == CCPS_CLOCK_SEEN && CLK_EN && !pix.clk_alive) |=> !CABLE_POWER_ENABLED;
    endproperty
    a_clock_loss: assert property (p_clock_loss)
        else $error("power kept after pixel clock stopped");

    property p_steady;
        (state_q == CCPS_CLOCK_SEEN && !hold_q && pix.clk_alive) |=>
            (state_q == CCPS_CLOCK_SEEN && CABLE_POWER_ENABLED);
    endproperty
    a_steady: assert property (p_steady)
        else $error("steady powered state not held");

    property p_status_read;
        (REG_RD && CLK_EN && status_hit) |=> (REG_RDATA == $past(status_w));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read does not match state");

    property p_status_bits;
        (REG_RD && CLK_EN && status_hit) |=>
            (REG_RDATA[ST_GROUND_BIT] == $past(CABLE_POWER_GROUNDED)
            && REG_RDATA[ST_WAIT_BIT] == ($past(state_q) == CCPS_CLOCK_WAIT)
            && REG_RDATA[ST_SENSE_BIT] == ($past(state_q) == CCPS_SENSE)
            && REG_RDATA[ST_CLK_SEEN_BIT] == ($past(state_q) == CCPS_CLOCK_SEEN)
            && REG_RDATA[ST_FOUND_BIT] == $past(CABLE_POWER_ENABLED));
    endproperty
    a_status_bits: assert property (p_status_bits)
        else $error("status field wrong");

    property p_reserved_zero;
        (REG_RD && CLK_EN && status_hit) |=> (REG_RDATA[31:7] == 25'h0 && !REG_RDATA[3]);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved status bits not zero");

    property p_read_one_cycle;
        (!REG_RD) |=> (REG_RDATA == 32'h0);
    endproperty
    a_read_one_cycle: assert property (p_read_one_cycle)
        else $error("read data outside the answer cycle");

    property p_excl;
        !(CABLE_POWER_ENABLED && CABLE_POWER_GROUNDED);
    endproperty
    a_excl: assert property (p_excl)
        else $error("power and ground together");

    property p_ground_hold;
        (state_q == CCPS_GROUNDED && CLK_EN && !hold_q && cam_short)
            |=> (state_q == CCPS_GROUNDED && CABLE_POWER_GROUNDED);
    endproperty
    a_ground_hold: assert property (p_ground_hold)
        else $error("ground released while short persists");

    property p_ground_release;
        (state_q == CCPS_GROUNDED && CLK_EN && !cam_short)
            |=> (state_q == CCPS_SENSE && !CABLE_POWER_GROUNDED);
    endproperty
    a_ground_release: assert property (p_ground_release)
        else $error("ground kept after short went away");

    property p_wait_hold;
        (state_q == CCPS_CLOCK_WAIT && CLK_EN && !hold_q && !wait_done)
            |=> (state_q == CCPS_CLOCK_WAIT && CABLE_POWER_ENABLED);
    endproperty
    a_wait_hold: assert property (p_wait_hold)
        else $error("clock wait left before its end");

    property p_wait_abort;
        (state_q == CCPS_CLOCK_WAIT && CLK_EN && wait_done && !pix.clk_alive)
            |=> (state_q == CCPS_SENSE && !CABLE_POWER_ENABLED);
    endproperty
    a_wait_abort: assert property (p_wait_abort)
        else $error("power kept after a clock wait with no pixel clock");

    property p_hold_off;
        (hold_q && CLK_EN)
            |=> (state_q == CCPS_SENSE && !CABLE_POWER_ENABLED && !CABLE_POWER_GROUNDED);
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("hold did not force sensing with pins off");

    property p_edge_alive;
        pix.clk_edge |=> pix.clk_alive;
    endproperty
    a_edge_alive: assert property (p_edge_alive)
        else $error("pixel clock edge not seen as a live clock");

    property p_freeze;
        (!CLK_EN) |=> ($stable(state_q) && $stable(wait_cnt_q) && $stable(REG_RDATA));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while the clock enable was low");

    c_power_up: cover property (state_q == CCPS_SENSE ##1 state_q == CCPS_CLOCK_WAIT);
    c_steady: cover property (state_q == CCPS_CLOCK_WAIT ##1 state_q == CCPS_CLOCK_SEEN);
    c_loss: cover property (state_q == CCPS_CLOCK_SEEN ##1 state_q == CCPS_SENSE);
    c_ground: cover property (state_q == CCPS_GROUNDED);
    c_abort: cover property (state_q == CCPS_CLOCK_WAIT ##1 state_q == CCPS_SENSE);
endmodule : ccps_sequencer
`default_nettype wire

// *** tb/ccps_cam_model.sv ***
// camera and cable model on the far side of the cable power pins
`timescale 1ns/1ps
`default_nettype none
module ccps_cam_model (
    input wire logic [1:0] mode,
    input wire logic clk_on,
    input wire logic power_on,
    output logic sense_match,
    output logic sense_short,
    output logic pixel_clk
);
    // mode 0 nothing attached, 1 powered-cable camera, 2 legacy short, 3 both at once
    assign sense_match = mode[0];
    assign sense_short = mode[1];

    // camera makes its pixel clock only while powered; still at 0 otherwise
    // edges sit 3 ns off the system clock edges
    always begin
        if (clk_on && power_on) begin
            #80;
            pixel_clk = ~pixel_clk;
        end else begin
            pixel_clk = 1'b0;
            @(clk_on or power_on);
            #3;
        end
    end
endmodule : ccps_cam_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the camera cable power sequencer
`timescale 1ns/1ps
`default_nettype none
module tb
    import ccps_pkg::*;
;
    localparam int unsigned WAIT = 50;
    localparam int unsigned LOSS = 32;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] reg_rdata;
    logic [1:0] cam_mode = 2'h0;
    logic cam_clk_on = 1'b0;
    logic sense_match;
    logic sense_short;
    logic pixel_clk;
    logic power_en;
    logic grounded;
    int n_mismatch = 0;
    int checks = 0;

    // 50 MHz system clock
    always #10 ref_clk = ~ref_clk;

    ccps_sequencer #(.WAIT_CYCLES(WAIT), .LOSS_CYCLES(LOSS)) DUT (
        .REF_CLK(ref_clk),
        .RESETN(resetn),
        .CLK_EN(clk_en),
        .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr),
        .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata),
        .CAM_SENSE_MATCH(sense_match),
        .CAM_SENSE_SHORT(sense_short),
        .PIXEL_CLK(pixel_clk),
        .CABLE_POWER_ENABLED(power_en),
        .CABLE_POWER_GROUNDED(grounded)
    );

    ccps_cam_model cam (
        .mode(cam_mode),
        .clk_on(cam_clk_on),
        .power_on(power_en),
        .sense_match(sense_match),
        .sense_short(sense_short),
        .pixel_clk(pixel_clk)
    );

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : chk_reg

    task automatic cycles(input int unsigned n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cycles

    // bounded wait for power or ground pin to reach a level
    task automatic wait_for(input logic sel_gnd, input logic val, input int unsigned limit);
        int unsigned i;
        logic s;
        s = sel_gnd ? grounded : power_en;
        for (i = 0; i < limit && s !== val; i++) begin
            @(posedge ref_clk);
            #1;
            s = sel_gnd ? grounded : power_en;
        end
        chk({31'h0, s}, {31'h0, val});
    endtask : wait_for

    // reset state: sensing, pins off, unmapped reads zero
    task automatic t_reset;
        chk({30'h0, power_en, grounded}, 32'h00000000);
        chk_reg(STATUS_OFFSET, 32'h00000010);
        chk_reg(8'h08, 32'h00000000);
        $display("test reset done");
    endtask : t_reset

    // nothing attached: sensing for 200 cycles, status writes ignored
    task automatic t_idle;
        wr(STATUS_OFFSET, 32'hffffffff);
        cycles(200);
        chk({30'h0, power_en, grounded}, 32'h00000000);
        chk_reg(STATUS_OFFSET, 32'h00000010);
        $display("test idle done");
    endtask : t_idle

    // short together with a match grounds the wires, then back to sensing
    task automatic t_short;
        cam_mode <= 2'h3;
        wait_for(1'b1, 1'b1, 20);
        chk({31'h0, power_en}, 32'h00000000);
        chk_reg(STATUS_OFFSET, 32'h00000002);
        cam_mode <= 2'h0;
        wait_for(1'b1, 1'b0, 20);
        chk_reg(STATUS_OFFSET, 32'h00000010);
        $display("test short done");
    endtask : t_short

    // hold keeps sensing; released, camera gets power, waits, then steady
    task automatic t_power;
        wr(CONTROL_OFFSET, 32'h1 << CTL_HOLD_BIT);
        cam_mode <= 2'h1;
        cam_clk_on <= 1'b1;
        cycles(40);
        chk({31'h0, power_en}, 32'h00000000);
        wr(CONTROL_OFFSET, 32'h00000000);
        wait_for(1'b0, 1'b1, 20);
        chk_reg(STATUS_OFFSET, 32'h00000045);
        cycles(WAIT - 10);
        chk_reg(STATUS_OFFSET, 32'h00000045);
        cycles(15);
        chk_reg(STATUS_OFFSET, 32'h00000061);
        cycles(100);
        chk_reg(STATUS_OFFSET, 32'h00000061);
        $display("test power done");
    endtask : t_power

    // camera unplugged: clock stops and power goes
    task automatic t_loss;
        cam_clk_on <= 1'b0;
        cam_mode <= 2'h0;
        wait_for(1'b0, 1'b0, LOSS + 12);
        chk_reg(STATUS_OFFSET, 32'h00000010);
        $display("test loss done");
    endtask : t_loss

    // clock enable low freezes the sequencer against a camera match
    task automatic t_freeze;
        @(posedge ref_clk);
        clk_en <= 1'b0;
        cam_mode <= 2'h1;
        cycles(30);
        chk({30'h0, power_en, grounded}, 32'h00000000);
        cam_mode <= 2'h0;
        @(posedge ref_clk);
        clk_en <= 1'b1;
        cycles(10);
        chk({30'h0, power_en, grounded}, 32'h00000000);
        chk_reg(STATUS_OFFSET, 32'h00000010);
        $display("test freeze done");
    endtask : t_freeze

    // camera found but no pixel clock: power drops when the wait ends
    task automatic t_noclk;
        cam_mode <= 2'h1;
        wait_for(1'b0, 1'b1, 20);
        cam_mode <= 2'h0;
        cycles(WAIT - 5);
        chk({31'h0, power_en}, 32'h00000001);
        wait_for(1'b0, 1'b0, 10);
        chk_reg(STATUS_OFFSET, 32'h00000010);
        $display("test no clock done");
    endtask : t_noclk

    // reset in mid-run while powered: pins off at once, sensing after release
    task automatic t_rst_mid;
        cam_mode <= 2'h1;
        wait_for(1'b0, 1'b1, 20);
        @(posedge ref_clk);
        resetn <= 1'b0;
        cam_mode <= 2'h0;
        cycles(3);
        chk({30'h0, power_en, grounded}, 32'h00000000);
        @(posedge ref_clk);
        resetn <= 1'b1;
        chk_reg(STATUS_OFFSET, 32'h00000010);
        cycles(10);
        chk({30'h0, power_en, grounded}, 32'h00000000);
        $display("test mid reset done");
    endtask : t_rst_mid

    // counts, verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset;
        t_idle;
        t_freeze;
        t_short;
        t_noclk;
        t_power;
        t_loss;
        t_rst_mid;
        end_sim;
    end

    // watchdog against a hang
    initial begin
        #200000;
        chk(32'h00000000, 32'h00000001);
        end_sim;
    end
endmodule : tb
`default_nettype wire
